// >>> touch_key_defs.svh
// register map, field positions, reset values and counts of the touch scan control
`ifndef TOUCH_KEY_DEFS_SVH
`define TOUCH_KEY_DEFS_SVH

`define TK_ADDR_CTRL     3'h0
`define TK_ADDR_CFG      3'h1
`define TK_ADDR_REFH     3'h2
`define TK_ADDR_REFL     3'h3
`define TK_ADDR_PRELOAD  3'h4
`define TK_ADDR_KEYSEL   3'h5

`define TK_BIT_OWNER     7
`define TK_BIT_SLOT_OVF  6
`define TK_BIT_START     5
`define TK_BIT_CF_OVF    4
`define TK_BIT_REF_OVF   3
`define TK_BIT_MODE      1
`define TK_BIT_BUSY      0

`define TK_CFG_SHARED    4
`define TK_CFG_REF_HI    3
`define TK_CFG_REF_LO    2
`define TK_CFG_FREQ_HI   1
`define TK_CFG_FREQ_LO   0

`define TK_CTRL_RESET    8'h00
`define TK_CFG_RESET     8'h03
`define TK_PRELOAD_RESET 8'h00
`define TK_KEYSEL_RESET  8'he4

`define TK_UNIT_LAST     5'h1f
`define TK_SLOT_LAST     8'hff
`define TK_CNT_LAST      16'hffff
`define TK_RAM_CAP       1'b0
`define TK_RAM_RESULT    1'b1

`endif

// >>> touch_key_pkg.sv
// types of the touch scan control
package touch_key_pkg;

   typedef enum logic [3:0]
   {
      st_idle  = 4'b0001,
      st_scan  = 4'b0010,
      st_fetch = 4'b0100,
      st_load  = 4'b1000
   } scan_state_type;

   typedef struct packed
   {
      scan_state_type st;
      logic           owner;
      logic           slot_ovf;
      logic           start;
      logic           cf_ovf;
      logic           ref_ovf;
      logic           mode;
      logic           busy;
      logic           auto_pri;
      logic           irq;
      logic [7:0]     cfg;
      logic [7:0]     preload;
      logic [7:0]     key_sel;
      logic [15:0]    ref_cnt;
      logic [15:0]    cf_cnt;
      logic [4:0]     unit;
      logic [7:0]     slot;
      logic [1:0]     slot_idx;
      logic [2:0]     div;
      logic [9:0]     cap;
      logic [7:0]     rdata;
      logic           ram_we;
      logic [2:0]     ram_addr;
      logic [15:0]    ram_wdata;
      logic           key_en;
      logic           ref_en;
      logic [2:0]     key_sync;
      logic [2:0]     ref_sync;
   } state_type;

endpackage : touch_key_pkg

// >>> touch_key_scan_control.sv
// shared start, mode, flag, ram arbitration and counter control of the touch key scanner
//
// Overview of operation
// (R01) Touch data RAM goes to processor when owner bit is 0, scanner when 1.
// (R02) Auto scan holds RAM priority from start edge until busy falls.
// (R03) Software should set owner bit to 1 while auto scan runs.
// (R04) Hardware slot overflow sets the interrupt flag; software setting it does not.
// (R05) Auto mid-scan overflow clears counters, reloads slot counter, no overflow flag.
// (R06) Auto scan completion sets flags, stops oscillators, switches counters off.
// (R07) Manual overflow sets flags, stops oscillators, switches counters off.
// (R08) Start bit low clears C/F, reference and unit counters, not slot counter.
// (R09) Start bit rising edge switches counters and oscillators on.
// (R10) C/F counter overflow sets sticky flag, cleared only by writing zero.
// (R11) Reference counter overflow sets sticky flag, cleared only by writing zero.
// (R12) Mode bit 0 selects auto scan, 1 selects manual scan.
// (R13) In manual mode software sets capacitor first and reads result after.
// (R14) Auto mode fetches capacitor values from RAM and stores results there.
// (R15) Auto mode scans slots in key select order until all are done.
// (R16) Busy rises with start and falls at the ending slot overflow.
// (R17) Software keeps the three configuration test bits at zero.
// (R18) Shared slot select 0 uses own slot counter, 1 uses module 0.
// (R19) Reference counter clock is system clock divided by 1, 2, 4 or 8.
// (R20) Oscillator frequency code selects 500 to 2000 kHz, resets to 11.
// (R21) Manual overflow stops reference counter and holds its count.
// (R22) Auto mode clears reference counter after slots 0-2, keeps it after 3.
// (R23) Slot overflow after 256 minus preload units of 32 slot clocks.
`timescale 1ns/100ps
`include "touch_key_defs.svh"

module touch_key_scan_control
   import touch_key_pkg::*;
#(
   parameter int SLOTS = 4
)
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [2:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        irq_ack_i,
   output logic             touch_irq_o,
   input  wire logic        key_osc_i,
   input  wire logic        ref_osc_i,
   output logic             key_osc_en_o,
   output logic             ref_osc_en_o,
   output logic      [1:0]  osc_freq_sel_o,
   output logic             shared_slot_sel_o,
   output logic      [1:0]  key_select_o,
   output logic      [9:0]  ref_cap_o,
   output logic             ram_grant_scan_o,
   output logic             ram_we_o,
   output logic      [2:0]  ram_addr_o,
   output logic      [15:0] ram_wdata_o,
   input  wire logic [15:0] ram_rdata_i
);

   // the slot index is two bits wide, so more than four slots cannot be served
   if (SLOTS < 1 || SLOTS > 4)
   begin : g_bad_slots
      $error("SLOTS must lie in 1 to 4");
   end

   localparam logic [1:0] LAST_SLOT = 2'(SLOTS - 1);

   state_type s;
   state_type next_s;
   logic      key_edge;
   logic      ref_edge;
   logic      ref_tick;
   logic      ctrl_wr;
   logic      start_rise;
   logic      slot_evt;
   logic      mid_evt;
   logic      done_evt;

   // one enable pulse per divided reference counter clock
   function automatic logic div_hit(input logic [1:0] sel, input logic [2:0] cnt);
      case (sel)
         2'h0:    div_hit = 1'b1;
         2'h1:    div_hit = cnt[0];
         2'h2:    div_hit = &cnt[1:0];
         default: div_hit = &cnt;
      endcase
   endfunction : div_hit

   always_comb
   begin
      next_s     = s;
      key_edge   = s.key_sync[1] & ~s.key_sync[2];
      ref_edge   = s.ref_sync[1] & ~s.ref_sync[2];
      ref_tick   = div_hit(s.cfg[`TK_CFG_REF_HI:`TK_CFG_REF_LO], s.div); // see (R19)
      ctrl_wr    = wr_i && addr_i == `TK_ADDR_CTRL;
      start_rise = ctrl_wr && wdata_i[`TK_BIT_START] && !s.start;
      slot_evt   = 1'b0;
      mid_evt    = 1'b0;
      done_evt   = 1'b0;

      next_s.key_sync = {s.key_sync[1:0], key_osc_i};
      next_s.ref_sync = {s.ref_sync[1:0], ref_osc_i};
      next_s.div      = s.div + 3'h1;
      next_s.ram_we   = 1'b0;
      next_s.rdata    = 8'h00;

      if (rd_i)
      begin
         case (addr_i)
            `TK_ADDR_CTRL:    next_s.rdata = {s.owner, s.slot_ovf, s.start, s.cf_ovf,
                                              s.ref_ovf, 1'b0, s.mode, s.busy};
            `TK_ADDR_CFG:     next_s.rdata = s.cfg;
            `TK_ADDR_REFH:    next_s.rdata = s.ref_cnt[15:8];
            `TK_ADDR_REFL:    next_s.rdata = s.ref_cnt[7:0];
            `TK_ADDR_PRELOAD: next_s.rdata = s.preload;
            `TK_ADDR_KEYSEL:  next_s.rdata = s.key_sel;
            default:          next_s.rdata = 8'h00;
         endcase
      end

      // software writes first so that hardware events below win over a clear
      if (ctrl_wr)
      begin
         next_s.owner = wdata_i[`TK_BIT_OWNER];
         next_s.start = wdata_i[`TK_BIT_START];
         next_s.mode  = wdata_i[`TK_BIT_MODE];
         if (wdata_i[`TK_BIT_SLOT_OVF])
            next_s.slot_ovf = 1'b1; // see (R04)
         else
            next_s.slot_ovf = 1'b0;
         if (!wdata_i[`TK_BIT_CF_OVF])
            next_s.cf_ovf = 1'b0; // see (R10)
         if (!wdata_i[`TK_BIT_REF_OVF])
            next_s.ref_ovf = 1'b0; // see (R11)
      end
      if (wr_i && addr_i == `TK_ADDR_CFG)
         next_s.cfg = wdata_i;
      if (wr_i && addr_i == `TK_ADDR_PRELOAD)
         next_s.preload = wdata_i;
      if (wr_i && addr_i == `TK_ADDR_KEYSEL)
         next_s.key_sel = wdata_i;
      if (irq_ack_i)
         next_s.irq = 1'b0;

      // start low keeps the measuring counters at zero but the slot counter alone
      if (!s.start)
      begin
         next_s.cf_cnt  = 16'h0000; // see (R08)
         next_s.ref_cnt = 16'h0000;
         next_s.unit    = 5'h00;
      end

      case (s.st)
         st_idle:
         begin
            if (start_rise)
            begin
               next_s.busy     = 1'b1; // see (R16)
               next_s.key_en   = 1'b1; // see (R09)
               next_s.ref_en   = 1'b1;
               next_s.slot     = s.preload;
               next_s.slot_idx = 2'h0;
               next_s.auto_pri = !wdata_i[`TK_BIT_MODE]; // see (R02)
               if (wdata_i[`TK_BIT_MODE])
                  next_s.st = st_scan; // see (R12)
               else
                  next_s.st = st_fetch;
            end
         end
         st_fetch:
         begin
            next_s.ram_addr = {`TK_RAM_CAP, s.slot_idx}; // see (R14)
            next_s.st       = st_load;
         end
         st_load:
         begin
            next_s.cap = ram_rdata_i[9:0];
            next_s.st  = st_scan;
         end
         st_scan:
         begin
            if (key_edge)
            begin
               next_s.cf_cnt = s.cf_cnt + 16'h0001;
               if (s.cf_cnt == `TK_CNT_LAST)
                  next_s.cf_ovf = 1'b1; // see (R10)
            end
            if (ref_tick)
            begin
               next_s.ref_cnt = s.ref_cnt + 16'h0001;
               if (s.ref_cnt == `TK_CNT_LAST)
                  next_s.ref_ovf = 1'b1; // see (R11)
            end
            // slot clock is the reference oscillator, 32 edges per unit
            if (ref_edge)
            begin
               next_s.unit = s.unit + 5'h01; // see (R23)
               if (s.unit == `TK_UNIT_LAST)
               begin
                  next_s.slot = s.slot + 8'h01;
                  slot_evt    = s.slot == `TK_SLOT_LAST;
               end
            end
            if (slot_evt && !s.mode)
            begin
               next_s.ram_we    = 1'b1; // see (R14)
               next_s.ram_addr  = {`TK_RAM_RESULT, s.slot_idx};
               next_s.ram_wdata = s.cf_cnt;
            end
            if (slot_evt && !s.mode && s.slot_idx != LAST_SLOT)
            begin
               mid_evt         = 1'b1;
               next_s.cf_cnt   = 16'h0000; // see (R05)
               next_s.ref_cnt  = 16'h0000; // see (R22)
               next_s.unit     = 5'h00;
               next_s.slot     = s.preload;
               next_s.slot_idx = s.slot_idx + 2'h1; // see (R15)
               next_s.st       = st_fetch;
            end
            else if (slot_evt)
            begin
               // counts freeze here because the idle state no longer advances them
               done_evt        = 1'b1;
               next_s.slot_ovf = 1'b1; // see (R06)
               next_s.irq      = 1'b1; // see (R07)
               next_s.busy     = 1'b0; // see (R16)
               next_s.auto_pri = 1'b0;
               next_s.key_en   = 1'b0;
               next_s.ref_en   = 1'b0;
               next_s.cf_cnt   = s.cf_cnt;
               next_s.ref_cnt  = s.ref_cnt; // see (R21)
               next_s.st       = st_idle;
            end
         end
         default:
         begin
            next_s.st = st_idle;
         end
      endcase

      // dropping start aborts a scan in flight
      if (ctrl_wr && !wdata_i[`TK_BIT_START] && s.st != st_idle && !done_evt)
      begin
         next_s.busy     = 1'b0;
         next_s.auto_pri = 1'b0;
         next_s.key_en   = 1'b0;
         next_s.ref_en   = 1'b0;
         next_s.st       = st_idle;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         s          <= '0;
         s.st       <= st_idle;
         s.cfg      <= `TK_CFG_RESET; // see (R20)
         s.preload  <= `TK_PRELOAD_RESET;
         s.key_sel  <= `TK_KEYSEL_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign rdata_o           = s.rdata;
   assign touch_irq_o       = s.irq;
   assign key_osc_en_o      = s.key_en;
   assign ref_osc_en_o      = s.ref_en;
   assign osc_freq_sel_o    = s.cfg[`TK_CFG_FREQ_HI:`TK_CFG_FREQ_LO]; // see (R20)
   assign shared_slot_sel_o = s.cfg[`TK_CFG_SHARED]; // see (R18)
   assign key_select_o      = s.mode ? 2'h0 : s.key_sel[{s.slot_idx, 1'b0} +: 2]; // see (R15)
   assign ref_cap_o         = s.cap;
   assign ram_grant_scan_o  = s.owner | s.auto_pri; // see (R01)
   assign ram_we_o          = s.ram_we;
   assign ram_addr_o        = s.ram_addr;
   assign ram_wdata_o       = s.ram_wdata;

   chk_ram_owner_only: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R01)
      !s.auto_pri |-> ram_grant_scan_o == s.owner)
      else $error("ram grant does not follow owner bit");

   chk_auto_priority: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R02)
      (start_rise && !wdata_i[`TK_BIT_MODE]) || (s.auto_pri && s.busy)
         |=> (s.auto_pri && ram_grant_scan_o) || !s.busy)
      else $error("auto scan lost ram priority");

   chk_sw_ovf_quiet: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R04)
      ctrl_wr && wdata_i[`TK_BIT_SLOT_OVF] && !done_evt && !s.irq |=> !touch_irq_o)
      else $error("software overflow set raised the interrupt");

   chk_mid_slot: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R05)
      mid_evt |=> s.ref_cnt == 16'h0000 && s.unit == 5'h00 && s.slot == $past(s.preload)
         && s.cf_cnt == 16'h0000 && (!s.slot_ovf || $past(s.slot_ovf)) && s.busy)
      else $error("mid scan overflow handled wrongly");

   chk_scan_done: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R06)
      done_evt |=> s.slot_ovf && touch_irq_o && !s.busy && !key_osc_en_o && !ref_osc_en_o)
      else $error("scan end did not set flags or stop oscillators");

   chk_start_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R08)
      !s.start ##1 !s.start |-> s.cf_cnt == 16'h0000 && s.ref_cnt == 16'h0000)
      else $error("counters not cleared while start is low");

   chk_start_on: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R09)
      start_rise |=> s.busy && key_osc_en_o && ref_osc_en_o)
      else $error("start edge did not switch the scan on");

   chk_cf_sticky: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R10)
      s.cf_ovf && !(ctrl_wr && !wdata_i[`TK_BIT_CF_OVF]) |=> s.cf_ovf)
      else $error("cf overflow flag cleared without a zero write");

   chk_ref_sticky: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R11)
      s.ref_ovf && !(ctrl_wr && !wdata_i[`TK_BIT_REF_OVF]) |=> s.ref_ovf)
      else $error("reference overflow flag cleared without a zero write");

   chk_manual_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R21)
      done_evt && s.mode ##1 s.start |-> s.ref_cnt == $past(s.ref_cnt))
      else $error("reference count moved after manual overflow");

   chk_manual_stop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R07)
      done_evt && s.mode |=> s.slot_ovf && touch_irq_o && !key_osc_en_o && !ref_osc_en_o)
      else $error("manual overflow did not stop the scan");

   chk_mode_path: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R12)
      start_rise |=> (s.mode && s.st == st_scan) || (!s.mode && s.st == st_fetch))
      else $error("scan mode bit chose the wrong scan");

   chk_result_store: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R14)
      slot_evt && !s.mode |=> ram_we_o && ram_addr_o == {`TK_RAM_RESULT, $past(s.slot_idx)}
         && ram_wdata_o == $past(s.cf_cnt))
      else $error("slot result not stored in ram");

   chk_busy_fall: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R16)
      s.busy && !next_s.busy |-> slot_evt || (ctrl_wr && !wdata_i[`TK_BIT_START]))
      else $error("busy fell without a slot overflow");

   chk_ref_clock: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R19)
      s.st == st_scan && s.start && !ref_tick && !slot_evt |=> s.ref_cnt == $past(s.ref_cnt))
      else $error("reference count moved without a divided clock enable");

   chk_unit_prescale: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see (R23)
      s.st == st_scan && !(ref_edge && s.unit == `TK_UNIT_LAST) |=> s.slot == $past(s.slot))
      else $error("slot counter moved inside a unit");

endmodule : touch_key_scan_control

// >>> touch_osc_model.sv
// behavioural key and reference oscillators of one touch module
`timescale 1ns/100ps
module touch_osc_model
(
   input  wire logic key_en_i,
   input  wire logic ref_en_i,
   output logic      key_osc_o,
   output logic      ref_osc_o
);
   // periods off the system clock grid so the synchronisers see truly async edges
   initial key_osc_o = 1'b0;
   initial ref_osc_o = 1'b0;

   always
   begin
      if (key_en_i === 1'b1)
      begin
         #30.5 key_osc_o = 1'b1;
         #30.5 key_osc_o = 1'b0;
      end
      else
         @(key_en_i);
   end

   always
   begin
      if (ref_en_i === 1'b1)
      begin
         #41.5 ref_osc_o = 1'b1;
         #41.5 ref_osc_o = 1'b0;
      end
      else
         @(ref_en_i);
   end
endmodule : touch_osc_model

// >>> tb_touch_key_scan_control.sv
// self-checking bench of the touch scan control
`timescale 1ns/100ps
`include "touch_key_defs.svh"
module tb_touch_key_scan_control;
   localparam logic [7:0] RST [0:6] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'he4, 8'h00};
   logic        sys_clk_i, reset_n_i, wr_i, rd_i, irq_ack_i, irq, key_osc, ref_osc;
   logic        key_en, ref_en, shared, grant, ram_we, scan_auto;
   logic [2:0]  addr_i, ram_addr;
   logic [7:0]  wdata_i, rdata;
   logic [1:0]  freq, ksel, prev_ksel;
   logic [9:0]  cap, prev_cap;
   logic [15:0] ram_wdata, ram_rdata;
   logic [15:0] ram [0:7];
   int          n_mismatch, checked, widx;

   touch_key_scan_control #(.SLOTS(4)) uut
   (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .irq_ack_i(irq_ack_i), .touch_irq_o(irq),
      .key_osc_i(key_osc), .ref_osc_i(ref_osc), .key_osc_en_o(key_en), .ref_osc_en_o(ref_en),
      .osc_freq_sel_o(freq), .shared_slot_sel_o(shared), .key_select_o(ksel), .ref_cap_o(cap),
      .ram_grant_scan_o(grant), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
      .ram_wdata_o(ram_wdata), .ram_rdata_i(ram_rdata)
   );

   touch_osc_model osc
   (
      .key_en_i(key_en), .ref_en_i(ref_en), .key_osc_o(key_osc), .ref_osc_o(ref_osc)
   );

   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   // read is combinational: the scanner samples data in the cycle its address stands
   assign ram_rdata = ram[ram_addr];

   always @(posedge sys_clk_i)
   begin
      if (ram_we === 1'b1)
         ram[ram_addr] <= ram_wdata;
   end

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task chk_in(input string what, input int lo, input int hi, input logic [15:0] got);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0d..%0d seen %h", what, lo, hi, got);
      end
   endtask : chk_in

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // no latch on the pair: only read while the counter stands
   task ref_count(output logic [15:0] v);
      rd(`TK_ADDR_REFH, v[15:8]);
      rd(`TK_ADDR_REFL, v[7:0]);
   endtask : ref_count

   task ack_irq;
      @(posedge sys_clk_i);
      irq_ack_i <= 1'b1;
      @(posedge sys_clk_i);
      irq_ack_i <= 1'b0;
      #1 chk("irq after ack", 0, irq);
   endtask : ack_irq

   task wait_end(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 4000)
      begin
         @(posedge sys_clk_i);
         #1;
         n++;
         if (scan_auto && irq !== 1'b1)
            chk("auto ram priority", 1, grant);
         if (scan_auto && ram_we === 1'b1)
         begin
            chk("result address", {1'b1, widx[1:0]}, ram_addr);
            chk("slot capacitor", ram[widx][9:0], prev_cap);
            chk("slot key", 3 - widx, prev_ksel);
            chk_in("slot result", 60, 120, ram_wdata);
            if (widx < 3)
               chk("irq mid scan", 0, irq);
            widx++;
         end
         prev_cap = cap;
         prev_ksel = ksel;
      end
      chk("scan ended", 1, irq);
   endtask : wait_end

   task t_reset;
      logic [7:0] v;
      for (int a = 0; a < 7; a++)
      begin
         rd(a[2:0], v);
         chk("register reset", RST[a], v);
      end
      chk("freq select reset", 2'b11, freq);
   endtask : t_reset

   task t_config;
      logic [7:0] v;
      for (int f = 0; f < 4; f++)
      begin
         wr(`TK_ADDR_CFG, {3'b000, 1'b1, 2'b00, f[1:0]});
         #1 chk("freq select", f[1:0], freq);
         chk("shared slot", 1, shared);
      end
      wr(`TK_ADDR_CFG, 8'h03);
      #1 chk("shared slot", 0, shared);
      wr(`TK_ADDR_CTRL, 8'h80);
      #1 chk("owner grant", 1, grant);
      wr(`TK_ADDR_CTRL, 8'h00);
      #1 chk("owner grant", 0, grant);
   endtask : t_config

   // divide code doubles as shift count of the reference count
   task t_manual(input logic [1:0] div);
      logic [7:0]  v;
      logic [15:0] c, c2;
      int          n;
      wr(`TK_ADDR_CFG, {4'h0, div, 2'b11});
      wr(`TK_ADDR_PRELOAD, 8'hfe);
      wr(`TK_ADDR_CTRL, 8'h22);
      @(posedge sys_clk_i);
      #1 chk("osc enables on", 2'b11, {key_en, ref_en});
      rd(`TK_ADDR_CTRL, v);
      chk("busy while scanning", 8'h21, v & 8'h21);
      wait_end(n);
      n += 3;
      chk("osc enables off", 0, {key_en, ref_en});
      chk("manual grant", 0, grant);
      rd(`TK_ADDR_CTRL, v);
      chk("overflow and busy", 8'h40, v & 8'h41);
      ref_count(c);
      repeat (20) @(posedge sys_clk_i);
      ref_count(c2);
      chk("held ref count", c, c2);
      chk_in("ref count rate", (n >> div) - 4, (n >> div) + 2, c);
      ack_irq;
      wr(`TK_ADDR_CTRL, 8'h02);
      ref_count(c);
      chk("cleared ref count", 0, c);
   endtask : t_manual

   task t_soft_flag;
      logic [7:0] v;
      wr(`TK_ADDR_CTRL, 8'h40);
      repeat (2) @(posedge sys_clk_i);
      #1 chk("irq on soft flag", 0, irq);
      rd(`TK_ADDR_CTRL, v);
      chk("soft flag", 8'h40, v & 8'h40);
      wr(`TK_ADDR_CTRL, 8'h00);
   endtask : t_soft_flag

   // own = 1 keeps the ram claimed by software setting during the scan
   task t_auto(input logic own);
      logic [7:0]  v;
      logic [15:0] c;
      int          n;
      wr(`TK_ADDR_KEYSEL, 8'h1b);
      wr(`TK_ADDR_CTRL, {own, 7'h20});
      widx = 0;
      scan_auto = 1'b1;
      wait_end(n);
      scan_auto = 1'b0;
      chk("slots stored", 4, widx);
      chk("grant after scan", own, grant);
      chk("osc enables off", 0, {key_en, ref_en});
      rd(`TK_ADDR_CTRL, v);
      chk("overflow and busy", 8'h40, v & 8'h41);
      ref_count(c);
      chk_in("last slot ref count", 1, n / 3, c);
      ack_irq;
      wr(`TK_ADDR_CTRL, 8'h00);
   endtask : t_auto

   task end_of_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      #400000;
      n_mismatch++;
      end_of_test;
   end

   initial
   begin
      for (int i = 0; i < 8; i++)
         ram[i] = 16'h0050 + 16'(i) * 16'h0101;
      {reset_n_i, wr_i, rd_i, irq_ack_i, scan_auto} = 5'h00;
      {addr_i, wdata_i} = 11'h0;
      repeat (3) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      t_reset;
      t_config;
      t_manual(2'b00);
      t_manual(2'b11);
      t_soft_flag;
      t_auto(1'b0);
      t_auto(1'b1);
      end_of_test;
   end
endmodule : tb_touch_key_scan_control
